/* File: verilog/asr_pkg.sv */
/*
   package for the async sram host controller: pin carrier, request carrier, timing counts.
   assumes a 10 MHz mclk; all sram timings are met in whole clock cycles.
*/
package asr_pkg;
   localparam int unsigned ADDR_W        = 15;
   localparam int unsigned DATA_W        = 8;
   localparam int unsigned CLK_PERIOD_NS = 100;
   // sram figures, fast grade, in ns
   localparam int unsigned T_RC_NS       = 12;
   localparam int unsigned T_WC_NS       = 12;
   localparam int unsigned T_PWE_NS      = 8;
   localparam int unsigned T_SD_NS       = 7;
   localparam int unsigned T_HZWE_NS     = 7;
   localparam int unsigned T_ACE_NS      = 12;
   localparam int unsigned T_HZCE_NS     = 6;
   localparam int unsigned T_R_NS        = T_RC_NS;
   // least times round up, never below one cycle
   localparam int unsigned RD_CYC  = ((T_ACE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) + 1;
   localparam int unsigned WR_CYC  = (((T_HZWE_NS + T_SD_NS) > T_WC_NS ? (T_HZWE_NS + T_SD_NS) : T_WC_NS)
                                      + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TA_CYC  = (T_HZCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned REC_CYC = (T_R_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W   = 4;
   localparam logic [CNT_W-1:0] RD_CNT  = CNT_W'(RD_CYC);
   localparam logic [CNT_W-1:0] WR_CNT  = CNT_W'(WR_CYC);
   localparam logic [CNT_W-1:0] TA_CNT  = CNT_W'(TA_CYC);
   localparam logic [CNT_W-1:0] REC_CNT = CNT_W'(REC_CYC);
   localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              chipSelN;
      logic              writeStrobeN;
      logic              outGateN;
      logic [DATA_W-1:0] sharedDataLineOut;
      logic              sharedDataLineOeN;
   } asr_pins_t;

   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } asr_req_t;
endpackage

/* File: verilog/asr_sync.sv */
/*
   two-flop synchroniser for a bus of pin inputs.
   assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module asr_sync #(
   parameter int unsigned W = 8
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   // meta_reg feeds only sync_reg
   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= din;
         sync_reg <= meta_reg;
      end
   end
   assign dout = sync_reg;
endmodule
`default_nettype wire

/* File: verilog/asr_host.sv */
/*
   host controller for an asynchronous byte-wide static memory: one read or write per request.
   assumes a 10 MHz mclk, a synchronous active-low reset, and the memory on the pins of sramPins.
*/
// Behaviour
// - controller sets write data 7 ns before write end, holds 0 ns after
// - controller holds address through write, 8 ns setup to end, 0 ns hold
// - strobe-controlled write with gate low lasts turn-off plus data setup
// - controller never drives data lines while memory drives them
// - controller keeps write strobe high during every read
// - controller sets address before or with chip select falling
// - deselect before supply drop to 2.0 V, wait a read cycle after
`timescale 1ns/100ps
`default_nettype none
module asr_host
   import asr_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire asr_req_t          req,
   input  wire logic              reqValid,
   output logic                   reqReady,
   output logic [DATA_W-1:0]      rdData,
   output logic                   rdValid,
   output logic                   wrDone,
   input  wire logic              retainReq,
   output logic                   retainSafe,
   input  wire logic [DATA_W-1:0] sharedDataLineIn,
   output asr_pins_t              sramPins
);
   typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WR, ST_TURN, ST_RET, ST_REC} asr_state_t;

   asr_state_t        state_reg, state_next;
   logic [CNT_W-1:0]  cnt_reg, cnt_next;
   asr_pins_t         pins_reg, pins_next;
   logic [DATA_W-1:0] rdData_reg, rdData_next;
   logic              rdValid_reg, rdValid_next;
   logic              wrDone_reg, wrDone_next;
   logic              ready_reg, ready_next;
   logic              retSafe_reg, retSafe_next;
   logic [DATA_W-1:0] dataSync;
   logic              retainSync;

   asr_sync #(.W(DATA_W)) uDataSync (
      .clk  (mclk),
      .rstn (rstn),
      .din  (sharedDataLineIn),
      .dout (dataSync)
   );

   asr_sync #(.W(1)) uRetSync (
      .clk  (mclk),
      .rstn (rstn),
      .din  (retainReq),
      .dout (retainSync)
   );

   wire cntDone  = (cnt_reg == '0);
   wire logic [CNT_W-1:0] cntDec = cnt_reg - 1'b1;
   wire startReq = reqValid && ready_reg;

   function automatic asr_pins_t idlePins(input logic [ADDR_W-1:0] a);
      asr_pins_t p;
      p.addr              = a;
      p.chipSelN          = 1'b1;
      p.writeStrobeN      = 1'b1;
      p.outGateN          = 1'b1;
      p.sharedDataLineOut = DATA_RST;
      p.sharedDataLineOeN = 1'b1;
      return p;
   endfunction

   always_comb begin
      state_next   = state_reg;
      cnt_next     = cnt_reg;
      pins_next    = pins_reg;
      rdData_next  = rdData_reg;
      rdValid_next = 1'b0;
      wrDone_next  = 1'b0;
      ready_next   = ready_reg;
      retSafe_next = retSafe_reg;
      case (state_reg)
         ST_IDLE: begin
            if (retainSync) begin
               // deselect before any supply drop
               pins_next    = idlePins(pins_reg.addr);
               ready_next   = 1'b0;
               retSafe_next = 1'b1;
               state_next   = ST_RET;
            end else if (startReq && !req.write) begin
               // address and select change in the same edge, so address is never late
               pins_next.addr         = req.addr;
               pins_next.chipSelN     = 1'b0;
               pins_next.outGateN     = 1'b0;
               pins_next.writeStrobeN = 1'b1;
               pins_next.sharedDataLineOeN = 1'b1;
               ready_next = 1'b0;
               // full count, not count less one: the sample must clear both sync flops
               cnt_next   = RD_CNT;
               state_next = ST_RD;
            end else if (startReq) begin
               // gate high keeps memory off the bus; address, data, strobes set together
               pins_next.addr              = req.addr;
               pins_next.sharedDataLineOut = req.wdata;
               pins_next.sharedDataLineOeN = 1'b0;
               pins_next.outGateN          = 1'b1;
               pins_next.chipSelN          = 1'b0;
               pins_next.writeStrobeN      = 1'b0;
               ready_next = 1'b0;
               cnt_next   = WR_CNT - 1'b1;
               state_next = ST_WR;
            end
         end
         ST_RD: begin
            cnt_next = cntDec[CNT_W-1:0];
            if (cntDone) begin
               // sampled after the two-flop delay; pins held so data is stable meanwhile
               rdData_next  = dataSync;
               rdValid_next = 1'b1;
               pins_next    = idlePins(pins_reg.addr);
               cnt_next     = TA_CNT - 1'b1;
               state_next   = ST_TURN;
            end
         end
         ST_WR: begin
            cnt_next = cntDec[CNT_W-1:0];
            if (cntDone) begin
               // strobes rise first; address stays until the next request, data stays driven until the turnaround ends
               pins_next.writeStrobeN = 1'b1;
               pins_next.chipSelN     = 1'b1;
               wrDone_next = 1'b1;
               cnt_next    = TA_CNT - 1'b1;
               state_next  = ST_TURN;
            end
         end
         ST_TURN: begin
            cnt_next = cntDec[CNT_W-1:0];
            if (cntDone) begin
               // data released a cycle after strobes rose: hold time over 0 ns
               pins_next.sharedDataLineOeN = 1'b1;
               ready_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_RET: begin
            if (!retainSync) begin
               retSafe_next = 1'b0;
               cnt_next     = REC_CNT - 1'b1;
               state_next   = ST_REC;
            end
         end
         ST_REC: begin
            cnt_next = cntDec[CNT_W-1:0];
            if (cntDone) begin
               ready_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         default: begin
            pins_next  = idlePins(ADDR_RST);
            ready_next = 1'b0;
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state_reg   <= ST_IDLE;
         cnt_reg     <= '0;
         pins_reg    <= idlePins(ADDR_RST);
         rdData_reg  <= DATA_RST;
         rdValid_reg <= 1'b0;
         wrDone_reg  <= 1'b0;
         ready_reg   <= 1'b0;
         retSafe_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         pins_reg    <= pins_next;
         rdData_reg  <= rdData_next;
         rdValid_reg <= rdValid_next;
         wrDone_reg  <= wrDone_next;
         ready_reg   <= (state_reg == ST_IDLE && !retainSync && !startReq && !retSafe_reg) ? 1'b1 : ready_next;
         retSafe_reg <= retSafe_next;
      end
   end

   assign sramPins   = pins_reg;
   assign reqReady   = ready_reg;
   assign rdData     = rdData_reg;
   assign rdValid    = rdValid_reg;
   assign wrDone     = wrDone_reg;
   assign retainSafe = retSafe_reg;
endmodule
`default_nettype wire

/* File: tb/asr_host_monitor.sv */
/* checker for the async sram host: pin sequences and answers.
   bound to asr_host by the bench; sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module asr_host_monitor
   import asr_pkg::*;
(
   input wire logic      mclk,
   input wire logic      rstn,
   input wire logic      rdValid,
   input wire logic      wrDone,
   input wire logic      retainSafe,
   input wire asr_pins_t sramPins
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   wire logic allHigh = sramPins.chipSelN && sramPins.writeStrobeN && sramPins.outGateN;
   wire logic rdMode  = !sramPins.chipSelN && sramPins.writeStrobeN && !sramPins.outGateN;
   wire logic wrMode  = !sramPins.chipSelN && !sramPins.writeStrobeN;
   sequence rdStart; $fell(sramPins.chipSelN) && sramPins.writeStrobeN; endsequence
   sequence wrStart; $fell(sramPins.writeStrobeN); endsequence
   a_no_drive_read: assert property (rdMode |-> sramPins.sharedDataLineOeN)
      else $error("host drives data lines during read");
   a_strobe_high_read: assert property (!sramPins.outGateN |-> sramPins.writeStrobeN)
      else $error("write strobe low with output gate low");
   a_read_shape: assert property (rdStart |-> rdMode ##1 (rdMode && $stable(sramPins.addr))[*2] ##1 allHigh)
      else $error("read cycle shape wrong");
   a_read_answer: assert property (rdStart |-> ##3 rdValid ##1 !rdValid)
      else $error("read answer not three cycles after select");
   a_write_shape: assert property (wrStart |-> (wrMode && !sramPins.sharedDataLineOeN) ##1 allHigh)
      else $error("write cycle shape wrong");
   a_write_hold: assert property ($rose(sramPins.writeStrobeN) |-> !sramPins.sharedDataLineOeN
      && $stable(sramPins.sharedDataLineOut) && $stable(sramPins.addr) && sramPins.chipSelN)
      else $error("write data or address not held at write end");
   a_write_answer: assert property (wrStart |-> ##1 wrDone ##1 !wrDone)
      else $error("write done pulse misplaced");
   a_retain_idle: assert property (retainSafe |-> allHigh && sramPins.sharedDataLineOeN)
      else $error("memory not deselected while retaining");
endmodule
`default_nettype wire

/* File: tb/asr_sram_model.sv */
/* behavioural byte-wide static memory on the host pins.
   assumes the pin struct of asr_pkg; no pull on the data lines. */
`timescale 1ns/100ps
`default_nettype none
module asr_sram_model
   import asr_pkg::*;
(
   input  wire asr_pins_t    sramPins,
   output logic [DATA_W-1:0] sharedDataLineIn
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] junk = 8'h5a;
   logic              memDrives = 1'b0;
   // deselected means powered down and floating
   wire logic rdSel = !sramPins.chipSelN && sramPins.writeStrobeN && !sramPins.outGateN;
   wire logic wrSel = !sramPins.chipSelN && !sramPins.writeStrobeN;
   // turn-off 5 ns beats turn-on 12 ns, so handover never overlaps
   always @(rdSel) memDrives <= #(rdSel ? 12 : 5) rdSel;
   // a floating bus must not look like a stable last value
   always #37 junk = ~junk + 8'h01;
   always @(negedge wrSel) begin
      if (!sramPins.sharedDataLineOeN) mem[sramPins.addr] = sramPins.sharedDataLineOut;
   end
   assign sharedDataLineIn = !sramPins.sharedDataLineOeN ? sramPins.sharedDataLineOut
                           : memDrives ? mem[sramPins.addr] : junk;
endmodule
`default_nettype wire

/* File: tb/tb_asr_host.sv */
/* bench for asr_host: idle pins, write and read back, refusal while retaining.
   assumes asr_sram_model on the pins; the monitor is bound at the foot. */
`timescale 1ns/100ps
`default_nettype none
module tb_asr_host
   import asr_pkg::*;
;
   logic              mclk = 1'b0;
   logic              rstn = 1'b0;
   asr_req_t          req = '0;
   logic              reqValid = 1'b0;
   logic              retainReq = 1'b0;
   logic              reqReady, rdValid, wrDone, retainSafe;
   logic [DATA_W-1:0] rdData, sharedDataLineIn;
   asr_pins_t         sramPins;
   int                failures = 0;
   int                n_compared = 0;
   int                cycles = 0;
   asr_host asr_host_i (.mclk(mclk), .rstn(rstn), .req(req), .reqValid(reqValid), .reqReady(reqReady),
      .rdData(rdData), .rdValid(rdValid), .wrDone(wrDone), .retainReq(retainReq), .retainSafe(retainSafe),
      .sharedDataLineIn(sharedDataLineIn), .sramPins(sramPins));
   asr_sram_model asr_sram_model_i (.sramPins(sramPins), .sharedDataLineIn(sharedDataLineIn));
   always #50 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // one request; a write answers its count after the take, a read one edge later for the sync
   task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int k;
      int lat;
      lat = wr ? WR_CYC : RD_CYC + 1;
      @(posedge mclk);
      req <= '{write: wr, addr: a, wdata: d};
      reqValid <= 1'b1;
      k = 0;
      do begin @(posedge mclk); k++; end while (reqReady !== 1'b1 && k < 40);
      reqValid <= 1'b0;
      repeat (lat) @(posedge mclk);
      #1;
      chk({6'h00, rdValid, wrDone}, wr ? 8'h01 : 8'h02, "answer timing");
      if (!wr) chk(rdData, d, "read data");
   endtask
   task automatic sc_reset();
      #1;
      chk({4'h0, sramPins.chipSelN, sramPins.writeStrobeN, sramPins.outGateN, sramPins.sharedDataLineOeN},
          8'h0f, "idle pins");
      $display("done reset");
   endtask
   task automatic sc_write_read();
      logic [ADDR_W-1:0] adr [4] = '{15'h0000, 15'h7fff, 15'h1234, 15'h0001};
      logic [DATA_W-1:0] dat [4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
      for (int i = 0; i < 4; i++) access(1'b1, adr[i], dat[i]);
      for (int i = 3; i >= 0; i--) access(1'b0, adr[i], dat[i]);
      $display("done write read");
   endtask
   task automatic sc_retention();
      int k;
      @(posedge mclk);
      retainReq <= 1'b1;
      k = 0;
      do begin @(posedge mclk); k++; end while (retainSafe !== 1'b1 && k < 20);
      req <= '{write: 1'b1, addr: 15'h1234, wdata: 8'h3c};
      reqValid <= 1'b1;
      repeat (8) begin
         @(posedge mclk);
         #1;
         chk({5'h00, retainSafe, reqReady, sramPins.chipSelN}, 8'h05, "refused while retaining");
      end
      @(posedge mclk);
      reqValid <= 1'b0;
      retainReq <= 1'b0;
      access(1'b0, 15'h1234, 8'hff);
      $display("done retention");
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      sc_reset();
      sc_write_read();
      sc_retention();
      end_sim();
   end
endmodule
bind asr_host asr_host_monitor asr_host_monitor_i (.mclk(mclk), .rstn(rstn), .rdValid(rdValid),
   .wrDone(wrDone), .retainSafe(retainSafe), .sramPins(sramPins));
`default_nettype wire
